/* rtl/txy_map.svh */
`ifndef TXY_MAP_SVH
`define TXY_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define TXY_AW 8
`define TXY_OFF_MODE0 8'h00
`define TXY_OFF_MODE1 8'h04
`define TXY_OFF_VAL0 8'h08
`define TXY_OFF_VAL1 8'h0c
`define TXY_OFF_STOP 8'h10
`define TXY_OFF_EDGE 8'h14
`define TXY_OFF_IRQ 8'h18
`define TXY_OFF_SYS 8'h1c

// ---------------------------------------------------------------
// Mode register fields and codes
// ---------------------------------------------------------------
`define TXY_B_WRLATCH 3
`define TXY_B_LEVEL 4
`define TXY_B_EDGE 5
`define TXY_B_SRC 6
`define TXY_MD_MEAS_PER 3'h2
`define TXY_MD_MEAS_WID 3'h3
`define TXY_MD_WAVE 3'h4
`define TXY_MD_SHOT 3'h5
`define TXY_MD_PWM 3'h6

// ---------------------------------------------------------------
// Request flags, reset values, prescaler, responses
// ---------------------------------------------------------------
`define TXY_IRQ_TRG 0
`define TXY_IRQ_TMR 4
`define TXY_STOP_RST 2'h3
`define TXY_PRE_MAX 4'hf
`define TXY_RESP_OKAY 2'h0
`define TXY_RESP_SLVERR 2'h2

`endif

/* rtl/txy_pkg.sv */
`default_nettype none
`include "txy_map.svh"

package txy_pkg;

   typedef enum logic {ph_high, ph_low} txy_phase_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] cnt;
      logic [15:0] latch;
      logic pin;
      logic trg_prev;
      logic shot;
      txy_phase_t phase;
   } txy_tmr_t;

   typedef struct packed {
      txy_tmr_t [1:0] tmr;
      logic [3:0] pre;
      logic [1:0] stop;
      logic [1:0] edge_sel;
      logic [7:0] irq;
      logic low_speed;
      logic awready;
      logic aw_have;
      logic [`TXY_AW-1:0] awaddr;
      logic wready;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } txy_state_t;

endpackage

`default_nettype wire

/* rtl/txy_timer_pair.sv */
// Function
// - Waveform mode: underflow drives level latch out
// - Code 101 selects one-shot mode
// - Trigger edge per edge bits; sets flag
// - High pulse: pin low at selection
// - Trigger while stopped is ignored
// - High pulse: trigger high, underflow low
// - Low pulse: init high, trigger low, underflow high
// - Edge bit flip inverts pin immediately
// - One-shot/PWM count only from divide 2/16
// - Code 110 selects PWM on own pin
// - PWM rising edge sets timer flag
// - High m periods, low n periods
// - Stopped PWM write loads, pin high
// - Start: high interval first, then low, repeat
// - Latch-only values act after next underflow
// - Zero intervals force pin low or high
// - Zero interval suppresses PWM request
// - Bit 3 selects both or latch-only write
// - Latch write at underflow is unspecified
// - Count readable except measurement; latch never
// - Edge bits also set interrupt edges
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "txy_map.svh"

module txy_timer_pair (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Write address channel
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`TXY_AW-1:0] s_axi_awaddr,
   // Write data channel
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // Write response channel
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // Read address channel
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`TXY_AW-1:0] s_axi_araddr,
   // Read data channel
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Timer pins
   input wire logic first_trigger_input,
   input wire logic second_trigger_input,
   output logic first_timer_pin,
   output logic second_timer_pin
);

   txy_pkg::txy_state_t s_ff;
   txy_pkg::txy_state_t nxt_s;
   logic [1:0] trig_in;
   logic [1:0] trig_ev;
   logic [1:0] cnt_en;
   logic [1:0] uf;
   logic [1:0] mode_wr;
   logic [1:0] val_wr;
   logic [1:0] start_ev;
   logic wr_go;
   logic irq_wr;
   logic tick_fast;
   logic tick_slow;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Shared decode and prescaler ticks
   // ------------------------------------------------------------
   assign trig_in = {second_trigger_input, first_trigger_input};
   assign wr_go = s_ff.aw_have & s_ff.w_have & ~s_ff.bvalid;
   assign irq_wr = wr_go & (s_ff.awaddr == `TXY_OFF_IRQ);
   assign tick_fast = s_ff.pre[0];
   assign tick_slow = (s_ff.pre == `TXY_PRE_MAX);

   // ------------------------------------------------------------
   // Per-timer events
   // ------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_tmr
      localparam logic [`TXY_AW-1:0] MODE_OFF =
         (i == 0) ? `TXY_OFF_MODE0 : `TXY_OFF_MODE1;
      localparam logic [`TXY_AW-1:0] VAL_OFF =
         (i == 0) ? `TXY_OFF_VAL0 : `TXY_OFF_VAL1;
      logic [2:0] md;
      logic fast_only;
      logic tick;

      assign md = s_ff.tmr[i].mode[2:0];
      assign fast_only = (md == `TXY_MD_SHOT) | (md == `TXY_MD_PWM);
      // Edge select bit chooses rising (1) or falling (0)
      assign trig_ev[i] = s_ff.edge_sel[i] ?
         (trig_in[i] & ~s_ff.tmr[i].trg_prev) :
         (~trig_in[i] & s_ff.tmr[i].trg_prev);
      // Only divide 2 / divide 16 exist as count sources
      assign tick = s_ff.tmr[i].mode[`TXY_B_SRC] ?
         tick_slow : tick_fast;
      // Low speed blocks one-shot and PWM counting
      assign cnt_en[i] = ~s_ff.stop[i] & tick
         & ~(fast_only & s_ff.low_speed)
         & ((md != `TXY_MD_SHOT) | s_ff.tmr[i].shot);
      assign uf[i] = cnt_en[i] & (s_ff.tmr[i].cnt == 16'h0000);
      assign mode_wr[i] = wr_go & (s_ff.awaddr == MODE_OFF)
         & s_ff.wstrb[0];
      assign val_wr[i] = wr_go & (s_ff.awaddr == VAL_OFF);
      assign start_ev[i] = wr_go & (s_ff.awaddr == `TXY_OFF_STOP)
         & s_ff.wstrb[0] & s_ff.stop[i] & ~s_ff.wdata[i];

      // ---------------------------------------------------------
      // Checks
      // ---------------------------------------------------------
      sequence s_enter_shot;
         mode_wr[i] && (s_ff.wdata[2:0] == `TXY_MD_SHOT)
            && (md != `TXY_MD_SHOT);
      endsequence
      sequence s_shot_trig;
         (md == `TXY_MD_SHOT) && !s_ff.stop[i] && !s_ff.low_speed
            && trig_ev[i] && !mode_wr[i];
      endsequence
      a_wave_level: assert property (
         (md == `TXY_MD_WAVE) && uf[i] && !mode_wr[i]
         |=> s_ff.tmr[i].pin == $past(s_ff.tmr[i].mode[`TXY_B_LEVEL]))
         else $error("waveform pin not from level latch");
      a_shot_entry: assert property (
         s_enter_shot
         |=> s_ff.tmr[i].shot == 1'b0
            && s_ff.tmr[i].pin == $past(s_ff.wdata[`TXY_B_EDGE]))
         else $error("one-shot idle level wrong at selection");
      a_trig_flag: assert property (
         trig_ev[i] |=> s_ff.irq[`TXY_IRQ_TRG + i])
         else $error("trigger edge did not set request flag");
      a_stop_ignore: assert property (
         (md == `TXY_MD_SHOT) && s_ff.stop[i] && !s_ff.tmr[i].shot
            && !mode_wr[i]
         |=> $stable(s_ff.tmr[i].pin) && !s_ff.tmr[i].shot)
         else $error("trigger acted while timer stopped");
      a_shot_start: assert property (
         s_shot_trig
         |=> s_ff.tmr[i].shot
            && s_ff.tmr[i].pin != $past(s_ff.tmr[i].mode[`TXY_B_EDGE]))
         else $error("one-shot pulse did not start on trigger");
      a_shot_end: assert property (
         (md == `TXY_MD_SHOT) && s_ff.tmr[i].shot && uf[i]
            && !trig_ev[i] && !mode_wr[i]
         |=> !s_ff.tmr[i].shot
            && s_ff.tmr[i].pin == $past(s_ff.tmr[i].mode[`TXY_B_EDGE]))
         else $error("one-shot pulse did not end at underflow");
      a_edge_flip: assert property (
         mode_wr[i] && (md == `TXY_MD_SHOT)
            && (s_ff.wdata[2:0] == `TXY_MD_SHOT)
            && (s_ff.wdata[`TXY_B_EDGE]
               != s_ff.tmr[i].mode[`TXY_B_EDGE])
         |=> s_ff.tmr[i].pin != $past(s_ff.tmr[i].pin))
         else $error("edge bit flip did not invert pin");
      a_pwm_zero: assert property (
         (md == `TXY_MD_PWM) && (s_ff.tmr[i].latch[15:8] == 8'h00)
            && !val_wr[i] && !mode_wr[i]
         |=> !s_ff.tmr[i].pin)
         else $error("zero high interval did not force low");
      a_pwm_noirq: assert property (
         (md == `TXY_MD_PWM) && !s_ff.irq[`TXY_IRQ_TMR + i] && !irq_wr
            && ((s_ff.tmr[i].latch[15:8] == 8'h00)
               || (s_ff.tmr[i].latch[7:0] == 8'h00))
         |=> !s_ff.irq[`TXY_IRQ_TMR + i])
         else $error("request raised with a zero interval");
      a_write_both: assert property (
         val_wr[i] && (s_ff.wstrb[1:0] == 2'h3)
            && !s_ff.tmr[i].mode[`TXY_B_WRLATCH]
         |=> s_ff.tmr[i].cnt == $past(s_ff.wdata[15:0]))
         else $error("simultaneous write missed the counter");
      a_latch_only: assert property (
         val_wr[i] && s_ff.tmr[i].mode[`TXY_B_WRLATCH] && !cnt_en[i]
            && (md != `TXY_MD_SHOT)
         |=> $stable(s_ff.tmr[i].cnt))
         else $error("latch-only write reached the counter");
      a_stop_hold: assert property (
         s_ff.stop[i] && !val_wr[i] && !start_ev[i]
         |=> $stable(s_ff.tmr[i].cnt))
         else $error("count moved while stopped");
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.pre = s_ff.pre + 4'h1;

      if (s_axi_awvalid & s_ff.awready) begin
         nxt_s.aw_have = 1'b1;
         nxt_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_ff.wready) begin
         nxt_s.w_have = 1'b1;
         nxt_s.wdata = s_axi_wdata;
         nxt_s.wstrb = s_axi_wstrb;
      end
      if (s_ff.bvalid & s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      // Shared registers; timer registers handled below
      if (wr_go) begin
         nxt_s.aw_have = 1'b0;
         nxt_s.w_have = 1'b0;
         nxt_s.bvalid = 1'b1;
         case (s_ff.awaddr)
            `TXY_OFF_MODE0, `TXY_OFF_MODE1, `TXY_OFF_VAL0, `TXY_OFF_VAL1,
            `TXY_OFF_STOP, `TXY_OFF_EDGE, `TXY_OFF_IRQ, `TXY_OFF_SYS:
               nxt_s.bresp = `TXY_RESP_OKAY;
            default: nxt_s.bresp = `TXY_RESP_SLVERR;
         endcase
      end
      if (wr_go & s_ff.wstrb[0]) begin
         case (s_ff.awaddr)
            `TXY_OFF_STOP: nxt_s.stop = s_ff.wdata[1:0];
            `TXY_OFF_EDGE: nxt_s.edge_sel = s_ff.wdata[1:0];
            `TXY_OFF_IRQ: nxt_s.irq = s_ff.irq & ~s_ff.wdata[7:0];
            `TXY_OFF_SYS: nxt_s.low_speed = s_ff.wdata[0];
            default: nxt_s.low_speed = s_ff.low_speed;
         endcase
      end
      // Read side; the latch has no read path
      if (s_ff.rvalid & s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid & s_ff.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = `TXY_RESP_OKAY;
         nxt_s.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            `TXY_OFF_MODE0: nxt_s.rdata[7:0] = s_ff.tmr[0].mode;
            `TXY_OFF_MODE1: nxt_s.rdata[7:0] = s_ff.tmr[1].mode;
            `TXY_OFF_VAL0, `TXY_OFF_VAL1: begin
               if (s_ff.tmr[s_axi_araddr[2]].mode[2:0]
                     != `TXY_MD_MEAS_PER
                  && s_ff.tmr[s_axi_araddr[2]].mode[2:0]
                     != `TXY_MD_MEAS_WID) begin
                  nxt_s.rdata[15:0] =
                     s_ff.tmr[s_axi_araddr[2]].cnt;
               end
            end
            `TXY_OFF_STOP: nxt_s.rdata[1:0] = s_ff.stop;
            `TXY_OFF_EDGE: nxt_s.rdata[1:0] = s_ff.edge_sel;
            `TXY_OFF_IRQ: nxt_s.rdata[7:0] = s_ff.irq;
            `TXY_OFF_SYS: nxt_s.rdata[0] = s_ff.low_speed;
            default: nxt_s.rresp = `TXY_RESP_SLVERR;
         endcase
      end
      // Timers; flag sets come after the software clear
      for (int i = 0; i < 2; i++) begin
         nxt_s.tmr[i].trg_prev = trig_in[i];
         if (trig_ev[i]) begin
            nxt_s.irq[`TXY_IRQ_TRG + i] = 1'b1;
         end
         if (cnt_en[i]) begin
            nxt_s.tmr[i].cnt = uf[i] ? s_ff.tmr[i].latch
               : s_ff.tmr[i].cnt - 16'h0001;
         end
         case (s_ff.tmr[i].mode[2:0])
            `TXY_MD_WAVE: begin
               if (uf[i]) begin
                  nxt_s.tmr[i].pin =
                     s_ff.tmr[i].mode[`TXY_B_LEVEL];
                  nxt_s.irq[`TXY_IRQ_TMR + i] = 1'b1;
               end
            end
            `TXY_MD_SHOT: begin
               if (trig_ev[i] & ~s_ff.stop[i]
                  & ~s_ff.low_speed) begin
                  nxt_s.tmr[i].shot = 1'b1;
                  nxt_s.tmr[i].cnt = s_ff.tmr[i].latch;
                  nxt_s.tmr[i].pin =
                     ~s_ff.tmr[i].mode[`TXY_B_EDGE];
               end else if (uf[i]) begin
                  nxt_s.tmr[i].shot = 1'b0;
                  nxt_s.tmr[i].pin =
                     s_ff.tmr[i].mode[`TXY_B_EDGE];
                  nxt_s.irq[`TXY_IRQ_TMR + i] = 1'b1;
               end
            end
            `TXY_MD_PWM: begin
               if (uf[i] && s_ff.tmr[i].phase == txy_pkg::ph_high) begin
                  nxt_s.tmr[i].phase = txy_pkg::ph_low;
                  nxt_s.tmr[i].cnt = {8'h00,
                     s_ff.tmr[i].latch[7:0] - 8'h01};
                  nxt_s.tmr[i].pin = 1'b0;
               end else if (uf[i]) begin
                  nxt_s.tmr[i].phase = txy_pkg::ph_high;
                  nxt_s.tmr[i].cnt = {8'h00,
                     s_ff.tmr[i].latch[15:8] - 8'h01};
                  nxt_s.tmr[i].pin = 1'b1;
               end
            end
            default: begin
               if (uf[i]) begin
                  nxt_s.irq[`TXY_IRQ_TMR + i] = 1'b1;
               end
            end
         endcase
         if (mode_wr[i]) begin
            nxt_s.tmr[i].mode = s_ff.wdata[7:0];
            if (s_ff.wdata[2:0] == `TXY_MD_SHOT) begin
               if (s_ff.tmr[i].mode[2:0] != `TXY_MD_SHOT) begin
                  nxt_s.tmr[i].shot = 1'b0;
                  nxt_s.tmr[i].pin =
                     s_ff.wdata[`TXY_B_EDGE];
               end else if (s_ff.wdata[`TXY_B_EDGE]
                  != s_ff.tmr[i].mode[`TXY_B_EDGE]) begin
                  nxt_s.tmr[i].pin = ~s_ff.tmr[i].pin;
               end
            end
         end
         // Latch-only write racing an underflow: reload uses the old latch value
         if (val_wr[i]) begin
            if (s_ff.wstrb[0]) begin
               nxt_s.tmr[i].latch[7:0] = s_ff.wdata[7:0];
            end
            if (s_ff.wstrb[1]) begin
               nxt_s.tmr[i].latch[15:8] = s_ff.wdata[15:8];
            end
            if (!s_ff.tmr[i].mode[`TXY_B_WRLATCH]) begin
               if (s_ff.wstrb[0]) begin
                  nxt_s.tmr[i].cnt[7:0] = s_ff.wdata[7:0];
               end
               if (s_ff.wstrb[1]) begin
                  nxt_s.tmr[i].cnt[15:8] = s_ff.wdata[15:8];
               end
            end
            if (s_ff.tmr[i].mode[2:0] == `TXY_MD_PWM
               && s_ff.stop[i]) begin
               nxt_s.tmr[i].pin = 1'b1;
               nxt_s.tmr[i].phase = txy_pkg::ph_high;
            end
         end
         if (start_ev[i]
            && s_ff.tmr[i].mode[2:0] == `TXY_MD_PWM) begin
            nxt_s.tmr[i].phase = txy_pkg::ph_high;
            nxt_s.tmr[i].cnt = {8'h00,
               s_ff.tmr[i].latch[15:8] - 8'h01};
            nxt_s.tmr[i].pin = 1'b1;
         end
         if (s_ff.tmr[i].mode[2:0] == `TXY_MD_PWM) begin
            if (nxt_s.tmr[i].latch[15:8] == 8'h00) begin
               nxt_s.tmr[i].pin = 1'b0;
            end else if (nxt_s.tmr[i].latch[7:0] == 8'h00) begin
               nxt_s.tmr[i].pin = 1'b1;
            end
            if (nxt_s.tmr[i].pin && !s_ff.tmr[i].pin
               && s_ff.tmr[i].latch[15:8] != 8'h00
               && s_ff.tmr[i].latch[7:0] != 8'h00
               && nxt_s.tmr[i].latch[15:8] != 8'h00
               && nxt_s.tmr[i].latch[7:0] != 8'h00) begin
               nxt_s.irq[`TXY_IRQ_TMR + i] = 1'b1;
            end
         end
      end

      nxt_s.awready = ~nxt_s.aw_have & ~nxt_s.bvalid;
      nxt_s.wready = ~nxt_s.w_have & ~nxt_s.bvalid;
      nxt_s.arready = ~nxt_s.rvalid;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.stop <= `TXY_STOP_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign s_axi_awready = s_ff.awready;
   assign s_axi_wready = s_ff.wready;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_arready = s_ff.arready;
   assign s_axi_rvalid = s_ff.rvalid;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
   assign first_timer_pin = s_ff.tmr[0].pin;
   assign second_timer_pin = s_ff.tmr[1].pin;

endmodule

`default_nettype wire

/* sim/txy_pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module txy_pin_partner (
   // Clock
   input wire logic mclk,
   // Trigger lines toward the timers
   output logic trg0,
   output logic trg1
);
   // Lines idle low between pulses
   initial begin
      trg0 = 1'b0;
      trg1 = 1'b0;
   end

   // Four-cycle high pulse: one rising and one falling edge
   task automatic pulse(input int idx);
      @(posedge mclk);
      if (idx == 0) begin
         trg0 <= 1'b1;
      end else begin
         trg1 <= 1'b1;
      end
      repeat (4) @(posedge mclk);
      trg0 <= 1'b0;
      trg1 <= 1'b0;
   endtask
endmodule

`default_nettype wire

/* sim/timer_xy_waveform_oneshot_pwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "txy_map.svh"

module timer_xy_waveform_oneshot_pwm_tb;
   logic mclk, rst, awv, wv, arv, awr, wr, bv, arr, rv;
   logic trg0, trg1, pin0, pin1;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, rdat;
   logic [1:0] rr, br, rrsp;
   logic [3:0] ws;
   logic brdy, rrdy;
   int miscompares, checks_done;

   // ---------------------------------------------------------------
   // Block and pin partner
   // ---------------------------------------------------------------
   txy_timer_pair dut_u (
      .mclk(mclk), .rst(rst),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat),
      .s_axi_rresp(rrsp),
      .first_trigger_input(trg0), .second_trigger_input(trg1),
      .first_timer_pin(pin0), .second_timer_pin(pin1)
   );

   txy_pin_partner ptn_u (.mclk(mclk), .trg0(trg0), .trg1(trg1));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tmo();
      chk(32'h0000_0000, 32'h0000_0001);
      end_sim();
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int i;
      brdy <= 1'b1;
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      for (i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      if (i == 40) tmo();
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      int i;
      rrdy <= 1'b1;
      arv <= 1'b1;
      ara <= a;
      for (i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (arr) arv <= 1'b0;
         d = rdat;
         r = rrsp;
         if (rv) break;
      end
      if (i == 40) tmo();
   endtask

   // Bounded wait for a pin level; running out counts as a miss
   task automatic wpin(input int p, input logic v, input int b);
      int i;
      checks_done++;
      for (i = 0; i < b; i++) begin
         if ((p == 0 ? pin0 : pin1) === v) break;
         @(posedge mclk);
         #1;
      end
      if (i == b) tmo();
   endtask

   // Cycles a pin stays at one level, capped at 100
   task automatic meas(input int p, input logic v, output int k);
      k = 0;
      while ((p == 0 ? pin0 : pin1) === v && k < 100) begin
         @(posedge mclk);
         #1;
         k++;
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      axr(`TXY_OFF_STOP, rd, rr);
      chk(rd, 32'h0000_0003);
      axr(`TXY_OFF_MODE0, rd, rr);
      chk(rd, 32'h0000_0000);
      axr(8'h40, rd, rr);
      chk({30'h0, rr}, {30'h0, `TXY_RESP_SLVERR});
      axw(8'h40, 32'h0000_0000);
      chk({30'h0, br}, {30'h0, `TXY_RESP_SLVERR});
      ws <= 4'he;
      axw(`TXY_OFF_MODE1, 32'h0000_0006);
      ws <= 4'hf;
      axr(`TXY_OFF_MODE1, rd, rr);
      chk(rd, 32'h0000_0000);
      ptn_u.pulse(1);
      repeat (2) @(posedge mclk);
      axr(`TXY_OFF_IRQ, rd, rr);
      chk(rd, 32'h0000_0002);
      axw(`TXY_OFF_IRQ, 32'h0000_00ff);
      axw(`TXY_OFF_SYS, 32'h0000_0000);
      chk({30'h0, br}, {30'h0, `TXY_RESP_OKAY});
   endtask

   task automatic t_wave();
      logic [31:0] a;
      axw(`TXY_OFF_MODE0, 32'h0000_0014);
      axw(`TXY_OFF_VAL0, 32'h0000_0005);
      axw(`TXY_OFF_STOP, 32'h0000_0002);
      wpin(0, 1'b1, 40);
      axw(`TXY_OFF_MODE0, 32'h0000_0004);
      wpin(0, 1'b0, 40);
      axw(`TXY_OFF_MODE0, 32'h0000_0014);
      wpin(0, 1'b1, 40);
      axr(`TXY_OFF_VAL0, a, rr);
      repeat (3) @(posedge mclk);
      axr(`TXY_OFF_VAL0, rd, rr);
      chk({31'h0, a !== rd}, 32'h0000_0001);
      chk({31'h0, rd < 32'h0000_0006}, 32'h0000_0001);
      axw(`TXY_OFF_STOP, 32'h0000_0003);
      axr(`TXY_OFF_VAL0, a, rr);
      repeat (20) @(posedge mclk);
      axr(`TXY_OFF_VAL0, rd, rr);
      chk(rd, a);
   endtask

   task automatic t_shot();
      axw(`TXY_OFF_EDGE, 32'h0000_0003);
      axw(`TXY_OFF_MODE0, 32'h0000_0005);
      axw(`TXY_OFF_VAL0, 32'h0000_0008);
      chk({31'h0, pin0}, 32'h0000_0000);
      ptn_u.pulse(0);
      repeat (8) @(posedge mclk);
      #1;
      chk({31'h0, pin0}, 32'h0000_0000);
      axw(`TXY_OFF_IRQ, 32'h0000_00ff);
      axw(`TXY_OFF_STOP, 32'h0000_0002);
      ptn_u.pulse(0);
      wpin(0, 1'b1, 10);
      axr(`TXY_OFF_IRQ, rd, rr);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      wpin(0, 1'b0, 60);
      axw(`TXY_OFF_MODE0, 32'h0000_0025);
      wpin(0, 1'b1, 4);
      ptn_u.pulse(0);
      wpin(0, 1'b0, 10);
      wpin(0, 1'b1, 60);
      axw(`TXY_OFF_STOP, 32'h0000_0003);
   endtask

   task automatic t_pwm();
      int h, l;
      axw(`TXY_OFF_MODE1, 32'h0000_0006);
      axw(`TXY_OFF_VAL1, 32'h0000_0302);
      repeat (2) @(posedge mclk);
      #1;
      chk({31'h0, pin1}, 32'h0000_0001);
      axw(`TXY_OFF_IRQ, 32'h0000_00ff);
      axw(`TXY_OFF_STOP, 32'h0000_0001);
      wpin(1, 1'b0, 40);
      wpin(1, 1'b1, 40);
      meas(1, 1'b1, h);
      meas(1, 1'b0, l);
      chk(h, 32'h0000_0006);
      chk(l, 32'h0000_0004);
      axr(`TXY_OFF_IRQ, rd, rr);
      chk(rd & 32'h0000_0020, 32'h0000_0020);
      axw(`TXY_OFF_MODE1, 32'h0000_000e);
      axw(`TXY_OFF_VAL1, 32'h0000_0104);
      repeat (30) @(posedge mclk);
      #1;
      wpin(1, 1'b0, 40);
      wpin(1, 1'b1, 40);
      meas(1, 1'b1, h);
      meas(1, 1'b0, l);
      chk(h, 32'h0000_0002);
      chk(l, 32'h0000_0008);
      axw(`TXY_OFF_VAL1, 32'h0000_0200);
      repeat (30) @(posedge mclk);
      axw(`TXY_OFF_IRQ, 32'h0000_00ff);
      meas(1, 1'b1, h);
      chk(h, 32'h0000_0064);
      axr(`TXY_OFF_IRQ, rd, rr);
      chk(rd & 32'h0000_0020, 32'h0000_0000);
      axw(`TXY_OFF_VAL1, 32'h0000_0000);
      repeat (30) @(posedge mclk);
      #1;
      meas(1, 1'b0, l);
      chk(l, 32'h0000_0064);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      awv = 1'b0;
      wv = 1'b0;
      arv = 1'b0;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h0000_0000;
      ws = 4'hf;
      brdy = 1'b0;
      rrdy = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_wave();
      t_shot();
      t_pwm();
      end_sim();
   end
endmodule

`default_nettype wire
